// ### dv/tb_top.sv
// self-checking bench for the timer channel control block; drives apb and
// channel inputs directly, expected values are written inline, pin levels after events come from exp_pin
`timescale 1ns/1ps
`include "tcv_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic clock_in = 0, nrst_in = 0, psel = 0, penable = 0, pwrite = 0, wrap = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, v;
  logic [2:0] pri = 0, sec = 0, match = 0, lv;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [2:0] pins, strobes, ch_irq;
  int errors = 0, checks = 0;
  int strobe_cnt = 0;
  logic [11:0] offs [6] = '{`TCV_OFS_CTL0, `TCV_OFS_CTL1, `TCV_OFS_CTL2, `TCV_OFS_VECTOR, `TCV_OFS_STATUS, `TCV_OFS_MASK};
  logic [31:0] vexp [4] = '{`TCV_VEC_CH1, `TCV_VEC_CH2, `TCV_VEC_WRAP, `TCV_VEC_NONE};

  always #5 clock_in = ~clock_in;

  // capture strobes are one-cycle pulses, so each one is counted once
  always @(posedge clock_in) begin
    if (nrst_in) strobe_cnt <= strobe_cnt + $countones(strobes);
  end

  tcv_channel_ctrl #(.NCH(3), .AW(12)) u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .primary_source_input_in(pri), .secondary_source_input_in(sec),
    .match_in(match), .counter_wrap_in(wrap), .pin_out(pins), .capture_strobe_out(strobes),
    .channel_irq_out(ch_irq), .irq_out(irq));

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ends mid-cycle so outputs are settled when looked at
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  // one apb transfer; request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // values read at an edge are those the slave samples there
    @(posedge clock_in);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clock_in);
      k++;
    end
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected pready exp 1 got 0");
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_eq(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask

  // one-cycle match and wrap pulse, then let the outputs follow
  task automatic pulse(input logic [2:0] p, input logic w);
    @(posedge clock_in);
    match <= p; wrap <= w;
    @(posedge clock_in);
    match <= 3'h0; wrap <= 1'b0;
    tick(2);
  endtask

  // pin level after one event: eq is the channel match, z the zero match
  function automatic logic exp_pin(input int m, input logic p, input logic eq, input logic z);
    case (m)
      1: return p | eq;
      2: return z ? 1'b0 : p ^ eq;
      3: return z ? 1'b0 : p | eq;
      4: return p ^ eq;
      5: return p & ~eq;
      6: return z ? 1'b1 : p ^ eq;
      7: return z ? 1'b1 : p & ~eq;
      default: return p;
    endcase
  endfunction

  initial begin
    v = $urandom(77);
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    foreach (offs[i]) rd_eq("reset value", offs[i], 32'hffffffff, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset done");
    // every source code, random levels on both inputs
    for (int s = 0; s < 4; s++) begin
      @(posedge clock_in);
      pri <= 3'($urandom); sec <= 3'($urandom);
      apb(1'b1, `TCV_OFS_CTL0, 32'(s) << 12);
      tick(4);
      lv[0] = (s == 0) ? pri[0] : (s == 1) ? sec[0] : (s == 3);
      rd_eq("input sample", `TCV_OFS_CTL0, 32'h8, {28'h0, lv[0], 3'h0});
    end
    $display("test source done");
    // each action mode 1 to 7 from a random start level, match then zero match
    for (int m = 1; m < 8; m++) begin
      lv[0] = 1'($urandom);
      apb(1'b1, `TCV_OFS_CTL1, {29'h0, lv[0], 2'h0});
      tick(2);
      `CHK("level pin", lv[0], pins[1])
      apb(1'b1, `TCV_OFS_CTL1, 32'(m) << 5);
      pulse(3'b010, 1'b0);
      lv[1] = exp_pin(m, lv[0], 1'b1, 1'b0);
      `CHK("match pin", lv[1], pins[1])
      pulse(3'b001, 1'b0);
      lv[2] = exp_pin(m, lv[1], 1'b0, 1'b1);
      `CHK("zero pin", lv[2], pins[1])
    end
    $display("test modes done");
    // all sources pending at once; channel zero has no enable
    apb(1'b1, `TCV_OFS_MASK, 32'h08);
    apb(1'b1, `TCV_OFS_CTL0, 32'h0);
    apb(1'b1, `TCV_OFS_CTL1, 32'h10);
    apb(1'b1, `TCV_OFS_CTL2, 32'h10);
    pulse(3'b111, 1'b1);
    `CHK("channel irq", 3'b110, ch_irq)
    `CHK("wrap irq", 1'b1, irq)
    foreach (vexp[i]) rd_eq("vector", `TCV_OFS_VECTOR, 32'hffffffff, vexp[i]);
    tick(2);
    `CHK("irq after vector", 4'h0, {ch_irq, irq})
    rd_eq("status", `TCV_OFS_STATUS, 32'h7f, 32'h07);
    apb(1'b1, `TCV_OFS_MASK, 32'h7f);
    tick(2);
    `CHK("unmasked irq", 1'b1, irq)
    apb(1'b1, `TCV_OFS_STATUS, 32'h7f);
    tick(2);
    `CHK("cleared irq", 1'b0, irq)
    $display("test vector done");
    // two rising edges without clearing: second one is an overrun
    for (int sy = 0; sy < 2; sy++) begin
      v = 32'h4100 | (32'(sy) << 11);
      apb(1'b1, `TCV_OFS_CTL2, v);
      for (int e = 0; e < 2; e++) begin
        @(posedge clock_in);
        pri[2] <= 1'b0;
        tick(3);
        @(posedge clock_in);
        pri[2] <= 1'b1;
        tick(5);
        rd_eq("capture flags", `TCV_OFS_CTL2, 32'h3, {30'h0, e[0], 1'b1});
      end
      apb(1'b1, `TCV_OFS_CTL2, v);
      rd_eq("cleared flags", `TCV_OFS_CTL2, 32'h3, 32'h0);
    end
    // two rising edges per sync setting, only channel two in capture mode
    `CHK("capture strobes", 4, strobe_cnt)
    $display("test capture done");
    wrap_up();
  end
endmodule

bind tcv_channel_ctrl tcv_channel_ctrl_sva #(.NCH(NCH), .AW(AW)) u_sva (.clock_in(clock_in), .nrst_in(nrst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pin_out(pin_out),
  .channel_irq_out(channel_irq_out), .irq_out(irq_out));

// ### dv/tcv_channel_ctrl_sva.sv
// checker for the timer channel control block: apb timing, read data and
// reset behaviour; assumes a single clock domain and the shared register header
`timescale 1ns/1ps
`include "tcv_regs.vh"

module tcv_channel_ctrl_sva #(
  parameter NCH = 3,
  parameter AW = 12
) (
  input wire clock_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [AW-1:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire [NCH-1:0] pin_out,
  input wire [NCH-1:0] channel_irq_out,
  input wire irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // every setup phase is answered after exactly one wait state
  chk_ready_timing: assert property ((psel_in && !penable_in) |-> ##2 pready_out) else $error("late ready");
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
  chk_ready_qual: assert property (pready_out |-> (psel_in && penable_in)) else $error("ready without access");
  chk_err_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  chk_err_data: assert property ((pslverr_out && !pwrite_in) |-> prdata_out == 32'h0) else $error("error data");
  // unused upper halves must read as zero
  chk_upper_zero: assert property ((pready_out && !pwrite_in) |-> prdata_out[31:16] == 16'h0) else $error("upper bits");
  chk_vector_codes: assert property ((pready_out && !pwrite_in && paddr_in == `TCV_OFS_VECTOR)
    |-> prdata_out inside {`TCV_VEC_NONE, `TCV_VEC_CH1, `TCV_VEC_CH2, `TCV_VEC_WRAP}) else $error("vector code");
  chk_reset_quiet: assert property ($rose(nrst_in) |-> (pin_out == 0 && irq_out == 0 && channel_irq_out == 0))
    else $error("outputs after reset");
endmodule

// ### inc/tcv_regs.vh
// register map, field positions, reset values and vector codes of the
// timer channel control block; definitions only, included by the design
`ifndef TCV_REGS_VH
`define TCV_REGS_VH

// byte offsets on the apb bus, one aligned 32-bit word each
`define TCV_OFS_CTL0 12'h000
`define TCV_OFS_CTL1 12'h004
`define TCV_OFS_CTL2 12'h008
`define TCV_OFS_VECTOR 12'h00c
`define TCV_OFS_STATUS 12'h010
`define TCV_OFS_MASK 12'h014

// channel_control field positions
`define TCV_CTL_EDGE_HI 15
`define TCV_CTL_EDGE_LO 14
`define TCV_CTL_SRC_HI 13
`define TCV_CTL_SRC_LO 12
`define TCV_CTL_SYNC 11
`define TCV_CTL_LATCHED 10
`define TCV_CTL_CAPMODE 8
`define TCV_CTL_MODE_HI 7
`define TCV_CTL_MODE_LO 5
`define TCV_CTL_IE 4
`define TCV_CTL_SAMPLE 3
`define TCV_CTL_LEVEL 2
`define TCV_CTL_OVR 1
`define TCV_CTL_FLAG 0

// status and mask layout: channel events, wrap, channel overruns
`define TCV_ST_CH_LO 0
`define TCV_ST_WRAP 3
`define TCV_ST_OVR_LO 4
`define TCV_ST_W 7

// reset values
`define TCV_CTL_RST 16'h0000
`define TCV_ST_RST 7'h00
`define TCV_MASK_RST 7'h00

// interrupt_vector codes
`define TCV_VEC_NONE 16'h0000
`define TCV_VEC_CH1 16'h0002
`define TCV_VEC_CH2 16'h0004
`define TCV_VEC_WRAP 16'h000a

// edge_mode_field codes
`define TCV_EDGE_NONE 2'h0
`define TCV_EDGE_RISE 2'h1
`define TCV_EDGE_FALL 2'h2
`define TCV_EDGE_BOTH 2'h3

// channel_source_select codes
`define TCV_SRC_PRIMARY 2'h0
`define TCV_SRC_SECONDARY 2'h1
`define TCV_SRC_LOW 2'h2
`define TCV_SRC_HIGH 2'h3

`endif

// ### src/tcv_channel_ctrl.v
// capture/compare control of three timer channels, the interrupt vector and
// an event status/mask pair, all behind an apb slave with one wait state.
// assumes the counter, its compare registers and the capture latches sit
// outside and talk through match_in, counter_wrap_in and capture_strobe_out.
`timescale 1ns/1ps
`include "tcv_regs.vh"

module tcv_channel_ctrl #(
  parameter NCH = 3,
  parameter AW = 12
) (
  input wire clock_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [AW-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire [NCH-1:0] primary_source_input_in,
  input wire [NCH-1:0] secondary_source_input_in,
  input wire [NCH-1:0] match_in,
  input wire counter_wrap_in,
  output reg [NCH-1:0] pin_out,
  output reg [NCH-1:0] capture_strobe_out,
  output reg [NCH-1:0] channel_irq_out,
  output reg irq_out
);

  // per-channel control fields
  reg [1:0] edge_mode_field_reg [0:NCH-1];
  reg [1:0] channel_source_select_reg [0:NCH-1];
  reg [NCH-1:0] sync_select_reg;
  reg [NCH-1:0] latched_input_bit_reg;
  reg [NCH-1:0] latch_mode_select_reg;
  reg [2:0] pin_action_mode_reg [0:NCH-1];
  reg [NCH-1:0] channel_irq_enable_reg;
  reg [NCH-1:0] driven_level_reg;
  reg [NCH-1:0] overrun_reg;
  reg [NCH-1:0] channel_event_flag_reg;
  // capture input path
  reg [NCH-1:0] sync_a_reg;
  reg [NCH-1:0] sync_b_reg;
  reg [NCH-1:0] level_prev_reg;
  // event status and mask
  reg [`TCV_ST_W-1:0] status_reg;
  reg [`TCV_ST_W-1:0] mask_reg;

  // each process has its own index, a shared loop variable would make the
  // combinational blocks wake each other without end
  integer i;
  integer ei;
  integer si;
  reg [1:0] rd_idx;
  reg [NCH-1:0] selected_input;
  reg [NCH-1:0] capture_level;
  reg [NCH-1:0] capture_event;
  reg [NCH-1:0] compare_event;
  reg [NCH-1:0] channel_event;
  reg [NCH-1:0] overrun_event;
  reg [31:0] rd_data;
  reg rd_err;

  // input mux per source code
  function src_pick;
    input [1:0] sel;
    input a;
    input b;
    begin
      case (sel)
        `TCV_SRC_PRIMARY: src_pick = a;
        `TCV_SRC_SECONDARY: src_pick = b;
        `TCV_SRC_LOW: src_pick = 1'b0;
        default: src_pick = 1'b1;
      endcase
    end
  endfunction

  // capture on the chosen edge of level against its previous sample
  function edge_hit;
    input [1:0] mode;
    input now;
    input prev;
    begin
      case (mode)
        `TCV_EDGE_RISE: edge_hit = now & ~prev;
        `TCV_EDGE_FALL: edge_hit = ~now & prev;
        `TCV_EDGE_BOTH: edge_hit = now ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // next pin level; the zero-match action is applied last so that on
  // channel zero, where both matches coincide, it overrides the first
  function out_next;
    input [2:0] mode;
    input cur;
    input level;
    input eq;
    input eq0;
    reg v;
    begin
      v = cur;
      case (mode)
        3'h0: v = level;
        3'h1: if (eq) v = 1'b1;
        3'h2: begin
          if (eq) v = ~cur;
          if (eq0) v = 1'b0;
        end
        3'h3: begin
          if (eq) v = 1'b1;
          if (eq0) v = 1'b0;
        end
        3'h4: if (eq) v = ~cur;
        3'h5: if (eq) v = 1'b0;
        3'h6: begin
          if (eq) v = ~cur;
          if (eq0) v = 1'b1;
        end
        3'h7: begin
          if (eq) v = 1'b0;
          if (eq0) v = 1'b1;
        end
        default: v = cur;
      endcase
      out_next = v;
    end
  endfunction

  // highest-priority pending source as a vector code
  function [15:0] vec_code;
    input p1;
    input p2;
    input pw;
    begin
      if (p1)
        vec_code = `TCV_VEC_CH1;
      else if (p2)
        vec_code = `TCV_VEC_CH2;
      else if (pw)
        vec_code = `TCV_VEC_WRAP;
      else
        vec_code = `TCV_VEC_NONE;
    end
  endfunction

  // pending terms seen by the vector; wrap uses the wrap mask bit as enable
  wire pend_ch1 = channel_event_flag_reg[1] & channel_irq_enable_reg[1];
  wire pend_ch2 = channel_event_flag_reg[2] & channel_irq_enable_reg[2];
  wire pend_wrap = status_reg[`TCV_ST_WRAP] & mask_reg[`TCV_ST_WRAP];
  wire [15:0] vector_code = vec_code(pend_ch1, pend_ch2, pend_wrap);

  // bus phases: the slave answers one cycle into the access phase
  wire access = psel_in & penable_in;
  wire done = access & pready_out;
  wire wr_done = done & pwrite_in;
  wire vec_read_done = done & ~pwrite_in & (paddr_in == `TCV_OFS_VECTOR);

  // source selection, capture level choice and event decode per channel
  always @* begin
    for (ei = 0; ei < NCH; ei = ei + 1) begin
      selected_input[ei] = src_pick(channel_source_select_reg[ei],
                                    primary_source_input_in[ei],
                                    secondary_source_input_in[ei]);
      // async capture looks at the raw pin, sync capture only at stage two
      capture_level[ei] = sync_select_reg[ei] ? sync_b_reg[ei] : selected_input[ei];
      capture_event[ei] = latch_mode_select_reg[ei] &
                          edge_hit(edge_mode_field_reg[ei], capture_level[ei], level_prev_reg[ei]);
      compare_event[ei] = ~latch_mode_select_reg[ei] & match_in[ei];
      channel_event[ei] = capture_event[ei] | compare_event[ei];
      overrun_event[ei] = capture_event[ei] & channel_event_flag_reg[ei];
    end
  end

  // read mux; unmapped offsets answer zero with an error
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    rd_idx = paddr_in[3:2];
    case (paddr_in)
      `TCV_OFS_CTL0, `TCV_OFS_CTL1, `TCV_OFS_CTL2: begin
        rd_data[`TCV_CTL_EDGE_HI:`TCV_CTL_EDGE_LO] = edge_mode_field_reg[rd_idx];
        rd_data[`TCV_CTL_SRC_HI:`TCV_CTL_SRC_LO] = channel_source_select_reg[rd_idx];
        rd_data[`TCV_CTL_SYNC] = sync_select_reg[rd_idx];
        rd_data[`TCV_CTL_LATCHED] = latched_input_bit_reg[rd_idx];
        rd_data[`TCV_CTL_CAPMODE] = latch_mode_select_reg[rd_idx];
        rd_data[`TCV_CTL_MODE_HI:`TCV_CTL_MODE_LO] = pin_action_mode_reg[rd_idx];
        rd_data[`TCV_CTL_IE] = channel_irq_enable_reg[rd_idx];
        rd_data[`TCV_CTL_SAMPLE] = selected_input[rd_idx];
        rd_data[`TCV_CTL_LEVEL] = driven_level_reg[rd_idx];
        rd_data[`TCV_CTL_OVR] = overrun_reg[rd_idx];
        rd_data[`TCV_CTL_FLAG] = channel_event_flag_reg[rd_idx];
      end
      `TCV_OFS_VECTOR: rd_data[15:0] = vector_code;
      `TCV_OFS_STATUS: rd_data[`TCV_ST_W-1:0] = status_reg;
      `TCV_OFS_MASK: rd_data[`TCV_ST_W-1:0] = mask_reg;
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer: data is latched in the first access cycle, so the vector
  // value read and the flag cleared on completion are the same source
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else if (access & ~pready_out) begin
      pready_out <= 1'b1;
      pslverr_out <= rd_err;
      prdata_out <= pwrite_in ? 32'h00000000 : rd_data;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // capture input synchroniser; stage one feeds only stage two
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a_reg <= {NCH{1'b0}};
      sync_b_reg <= {NCH{1'b0}};
      level_prev_reg <= {NCH{1'b0}};
    end else begin
      sync_a_reg <= selected_input;
      sync_b_reg <= sync_a_reg;
      // switching the sync bit may show one false edge; change it with capture off
      level_prev_reg <= capture_level;
    end
  end

  // channel control registers, flags and pins
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (i = 0; i < NCH; i = i + 1) begin
        edge_mode_field_reg[i] <= 2'h0;
        channel_source_select_reg[i] <= 2'h0;
        pin_action_mode_reg[i] <= 3'h0;
      end
      sync_select_reg <= {NCH{1'b0}};
      latched_input_bit_reg <= {NCH{1'b0}};
      latch_mode_select_reg <= {NCH{1'b0}};
      channel_irq_enable_reg <= {NCH{1'b0}};
      driven_level_reg <= {NCH{1'b0}};
      overrun_reg <= {NCH{1'b0}};
      channel_event_flag_reg <= {NCH{1'b0}};
      pin_out <= {NCH{1'b0}};
      capture_strobe_out <= {NCH{1'b0}};
      channel_irq_out <= {NCH{1'b0}};
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr_done && paddr_in == (`TCV_OFS_CTL0 + i * 4)) begin
          edge_mode_field_reg[i] <= pwdata_in[`TCV_CTL_EDGE_HI:`TCV_CTL_EDGE_LO];
          channel_source_select_reg[i] <= pwdata_in[`TCV_CTL_SRC_HI:`TCV_CTL_SRC_LO];
          sync_select_reg[i] <= pwdata_in[`TCV_CTL_SYNC];
          latch_mode_select_reg[i] <= pwdata_in[`TCV_CTL_CAPMODE];
          pin_action_mode_reg[i] <= pwdata_in[`TCV_CTL_MODE_HI:`TCV_CTL_MODE_LO];
          channel_irq_enable_reg[i] <= pwdata_in[`TCV_CTL_IE];
          driven_level_reg[i] <= pwdata_in[`TCV_CTL_LEVEL];
          // hardware events win over a software write of zero
          overrun_reg[i] <= pwdata_in[`TCV_CTL_OVR] | overrun_event[i];
          channel_event_flag_reg[i] <= pwdata_in[`TCV_CTL_FLAG] | channel_event[i];
        end else begin
          overrun_reg[i] <= overrun_reg[i] | overrun_event[i];
          if (channel_event[i])
            channel_event_flag_reg[i] <= 1'b1;
          else if (vec_read_done && i == 1 && prdata_out[15:0] == `TCV_VEC_CH1)
            channel_event_flag_reg[i] <= 1'b0;
          else if (vec_read_done && i == 2 && prdata_out[15:0] == `TCV_VEC_CH2)
            channel_event_flag_reg[i] <= 1'b0;
        end
        // input level held at each compare match
        if (compare_event[i])
          latched_input_bit_reg[i] <= selected_input[i];
        pin_out[i] <= out_next(pin_action_mode_reg[i], pin_out[i], driven_level_reg[i],
                               match_in[i], match_in[0]);
        capture_strobe_out[i] <= capture_event[i];
        channel_irq_out[i] <= channel_event_flag_reg[i] & channel_irq_enable_reg[i];
      end
    end
  end

  // sticky event status, write one to clear, set wins; mask gates irq_out
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= `TCV_ST_RST;
      mask_reg <= `TCV_MASK_RST;
      irq_out <= 1'b0;
    end else begin
      for (si = 0; si < NCH; si = si + 1) begin
        status_reg[`TCV_ST_CH_LO + si] <= channel_event[si] |
          (status_reg[`TCV_ST_CH_LO + si] &
           ~(wr_done && paddr_in == `TCV_OFS_STATUS && pwdata_in[`TCV_ST_CH_LO + si]));
        status_reg[`TCV_ST_OVR_LO + si] <= overrun_event[si] |
          (status_reg[`TCV_ST_OVR_LO + si] &
           ~(wr_done && paddr_in == `TCV_OFS_STATUS && pwdata_in[`TCV_ST_OVR_LO + si]));
      end
      status_reg[`TCV_ST_WRAP] <= counter_wrap_in |
        (status_reg[`TCV_ST_WRAP] &
         ~(wr_done && paddr_in == `TCV_OFS_STATUS && pwdata_in[`TCV_ST_WRAP]) &
         ~(vec_read_done && prdata_out[15:0] == `TCV_VEC_WRAP));
      if (wr_done && paddr_in == `TCV_OFS_MASK)
        mask_reg <= pwdata_in[`TCV_ST_W-1:0];
      irq_out <= |(status_reg & mask_reg);
    end
  end

endmodule
